// >>> hdl/dss_status_bank.sv
/*
 * Read-only status bank: loop operating state, soft limit flags,
 * highest-priority validated input and currently selected input.
 * Assumes state inputs come from on-chip state machines on ref_clk,
 * and the serial port logic presents a register address and read strobe.
 */
// Functional notes
// R1 - Soft limit bits 5/4: 1 beyond limit
// R2 - State 001 free run, 010 holdover
// R3 - 100 locked, 101 pre-locked2, 110 pre-locked
// R4 - Phase lost reported as 111
// R5 - Upper nibble: highest-priority validated input code
// R6 - No validated input reads 0000
// R7 - Lower nibble: currently selected input code
// R8 - Selected field follows actual selection
// R9 - Priority register is read-only
`timescale 1ns/1ps
`default_nettype none

module dss_status_bank
    import dss_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] first_loop_state,
    input  wire logic       first_loop_beyond_soft,
    input  wire logic       second_loop_beyond_soft,
    input  wire logic       any_input_valid,
    input  wire logic [3:0] top_priority_code,
    input  wire logic [3:0] selected_code,
    input  wire logic [6:0] reg_addr,
    input  wire logic       reg_rd,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_ff
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Operating state register
    // ------------------------------------------------------------
    logic [2:0] state_ff;
    logic       first_soft_ff;
    logic       second_soft_ff;
    wire logic  state_legal;
    wire logic [2:0] nxt_state;

    // Codes 000 and 011 are never reported; keep previous state instead
    assign state_legal = (first_loop_state == DSS_FREE_RUN)    ||
                         (first_loop_state == DSS_HOLDOVER)    ||
                         (first_loop_state == DSS_LOCKED)      ||
                         (first_loop_state == DSS_PRE_LOCKED2) ||
                         (first_loop_state == DSS_PRE_LOCKED)  ||
                         (first_loop_state == DSS_PHASE_LOST);     // R2 R3 R4
    assign nxt_state = state_legal ? first_loop_state : state_ff; // R2

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff       <= OPERATING_STATE_STATUS_RST[2:0];
            first_soft_ff  <= OPERATING_STATE_STATUS_RST[FIRST_SOFT_BIT];
            second_soft_ff <= OPERATING_STATE_STATUS_RST[SECOND_SOFT_BIT];
        end else begin
            state_ff       <= nxt_state;
            first_soft_ff  <= first_loop_beyond_soft;  // R1
            second_soft_ff <= second_loop_beyond_soft; // R1
        end
    end

    wire logic [7:0] op_word;
    assign op_word = {2'b00, first_soft_ff, second_soft_ff, 1'b0, state_ff}; // R1

    // ------------------------------------------------------------
    // Priority status register
    // ------------------------------------------------------------
    wire logic [3:0] top_in;
    logic      [3:0] top_ff;
    logic      [3:0] sel_ff;

    assign top_in = any_input_valid ? top_priority_code : DSS_CH_NONE; // R6

    dss_chan_filter u_top (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n_ff),
        .code_in    (top_in),
        .allow_none (1'b1),
        .code_ff    (top_ff)
    ); // R5

    // Driven by the real selection, which may lag priority in non-revertive mode
    dss_chan_filter u_sel (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n_ff),
        .code_in    (selected_code),
        .allow_none (1'b1),
        .code_ff    (sel_ff)
    ); // R7 R8

    wire logic [7:0] prio_word;
    assign prio_word = {top_ff, sel_ff}; // R5 R7

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Writes are ignored: nothing in this bank is writable
    wire logic unused_wr;
    assign unused_wr = reg_wr & (|reg_wdata); // R9

    wire logic [7:0] nxt_rdata;
    assign nxt_rdata = (reg_addr == OPERATING_STATE_STATUS_ADDR)     ? op_word   :
                       (reg_addr == SOURCE_PRIORITY_STATUS_LOW_ADDR) ? prio_word :
                       UNMAPPED_READ_VALUE;

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            reg_rdata_ff <= UNMAPPED_READ_VALUE;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_soft_flags;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        ##1 (first_soft_ff == $past(first_loop_beyond_soft)) && (second_soft_ff == $past(second_loop_beyond_soft));
    endproperty
    a_soft_flags: assert property (p_soft_flags) else $error("soft flag mismatch"); // R1

    property p_state_never_unused;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (state_ff != 3'b000) && (state_ff != 3'b011);
    endproperty
    a_state_never_unused: assert property (p_state_never_unused) else $error("unused state code"); // R2

    property p_state_follows;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (first_loop_state == DSS_LOCKED) |=> (state_ff == DSS_LOCKED);
    endproperty
    a_state_follows: assert property (p_state_follows) else $error("locked not reported"); // R3

    property p_phase_lost;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (first_loop_state == DSS_PHASE_LOST) |=> (state_ff == 3'b111);
    endproperty
    a_phase_lost: assert property (p_phase_lost) else $error("phase lost not 111"); // R4

    property p_top_code;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (any_input_valid && top_priority_code == DSS_CH_STANDBY) |=> (top_ff == 4'b1001);
    endproperty
    a_top_code: assert property (p_top_code) else $error("top code wrong"); // R5

    property p_none_valid;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        !any_input_valid |=> (top_ff == 4'b0000);
    endproperty
    a_none_valid: assert property (p_none_valid) else $error("top not zero"); // R6

    property p_sel_follows;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (selected_code == DSS_CH_FIRST_DIF) |=> (sel_ff == 4'b0101);
    endproperty
    a_sel_follows: assert property (p_sel_follows) else $error("selected not followed"); // R7 R8

    property p_read_only;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (reg_wr && !reg_rd && $stable(selected_code) && $stable(top_in) && $stable(first_loop_state))
        |=> $stable(prio_word) && $stable(reg_rdata_ff);
    endproperty
    a_read_only: assert property (p_read_only) else $error("write altered status"); // R9

    property p_free_run;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (first_loop_state == DSS_FREE_RUN) |=> (state_ff == 3'h1);
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run not 001"); // R2

    property p_holdover;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (first_loop_state == DSS_HOLDOVER) |=> (state_ff == 3'h2);
    endproperty
    a_holdover: assert property (p_holdover) else $error("holdover not 010"); // R2

    // An unused code from the state machine must not disturb the stored state
    property p_unused_holds;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        ((first_loop_state == 3'h0) || (first_loop_state == 3'h3)) |=> $stable(state_ff);
    endproperty
    a_unused_holds: assert property (p_unused_holds) else $error("unused code changed state"); // R2

    property p_pre_locked2;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (first_loop_state == DSS_PRE_LOCKED2) |=> (state_ff == 3'h5);
    endproperty
    a_pre_locked2: assert property (p_pre_locked2) else $error("second pre-lock not 101"); // R3

    property p_pre_locked;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (first_loop_state == DSS_PRE_LOCKED) |=> (state_ff == 3'h6);
    endproperty
    a_pre_locked: assert property (p_pre_locked) else $error("first pre-lock not 110"); // R3

    property p_op_read;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (reg_rd && (reg_addr == OPERATING_STATE_STATUS_ADDR)) |=> (reg_rdata_ff == $past(op_word));
    endproperty
    a_op_read: assert property (p_op_read) else $error("operating word read wrong"); // R1

    property p_prio_read;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (reg_rd && (reg_addr == SOURCE_PRIORITY_STATUS_LOW_ADDR)) |=> (reg_rdata_ff == $past(prio_word));
    endproperty
    a_prio_read: assert property (p_prio_read) else $error("priority word read wrong"); // R5 R7

    property p_write_ignored;
        @(posedge ref_clk) disable iff (!rst_n_ff)
        (unused_wr && !reg_rd) |=> $stable(reg_rdata_ff);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write reached read data"); // R9

endmodule

`default_nettype wire

// >>> hdl/dss_pkg.sv
/*
 * Package for the loop state and source status register bank.
 * Holds offsets, reset values, field positions and channel/state codes.
 * Assumes a single system clock domain and an 8-bit register read port.
 */
package dss_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [6:0] OPERATING_STATE_STATUS_ADDR     = 7'h09;
    // Offset not printed; chosen for this bank
    localparam logic [6:0] SOURCE_PRIORITY_STATUS_LOW_ADDR = 7'h0a;

    localparam logic [7:0] OPERATING_STATE_STATUS_RST      = 8'h01;
    localparam logic [7:0] SOURCE_PRIORITY_STATUS_LOW_RST  = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE             = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FIRST_SOFT_BIT  = 5;
    localparam int SECOND_SOFT_BIT = 4;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DSS_FREE_RUN    = 3'b001,
        DSS_HOLDOVER    = 3'b010,
        DSS_LOCKED      = 3'b100,
        DSS_PRE_LOCKED2 = 3'b101,
        DSS_PRE_LOCKED  = 3'b110,
        DSS_PHASE_LOST  = 3'b111
    } dss_loop_state_t;

    typedef enum logic [3:0] {
        DSS_CH_NONE       = 4'b0000,
        DSS_CH_FIRST_SE   = 4'b0011,
        DSS_CH_SECOND_SE  = 4'b0100,
        DSS_CH_FIRST_DIF  = 4'b0101,
        DSS_CH_SECOND_DIF = 4'b0110,
        DSS_CH_STANDBY    = 4'b1001
    } dss_channel_t;

endpackage

// >>> hdl/dss_chan_filter.sv
/*
 * Channel code filter: registers a channel code, passing only legal codes.
 * Assumes the input comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dss_chan_filter
    import dss_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] code_in,
    input  wire logic       allow_none,
    output logic      [3:0] code_ff
);

    // ------------------------------------------------------------
    // Legal code check
    // ------------------------------------------------------------
    wire logic legal_code;
    wire logic [3:0] nxt_code;

    assign legal_code = (code_in == DSS_CH_FIRST_SE)  || (code_in == DSS_CH_SECOND_SE)  ||
                        (code_in == DSS_CH_FIRST_DIF) || (code_in == DSS_CH_SECOND_DIF) ||
                        (code_in == DSS_CH_STANDBY)   || (allow_none && code_in == DSS_CH_NONE);
    // Unused codes hold the last good value so software never sees them
    assign nxt_code = legal_code ? code_in : code_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= SOURCE_PRIORITY_STATUS_LOW_RST[3:0];
        end else begin
            code_ff <= nxt_code;
        end
    end

endmodule

`default_nettype wire

// >>> verification/test_dss_status_bank.sv
/*
 * Self-checking bench for the loop state and source status bank.
 * Assumes dss_pkg and dss_status_bank are compiled first; one 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module test_dss_status_bank
    import dss_pkg::*;
;
    logic       ref_clk;
    logic       reset_n;
    logic [2:0] first_loop_state;
    logic       first_loop_beyond_soft;
    logic       second_loop_beyond_soft;
    logic       any_input_valid;
    logic [3:0] top_priority_code;
    logic [3:0] selected_code;
    logic [6:0] reg_addr;
    logic       reg_rd;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata_ff;
    logic [7:0] exp_q[$];
    logic [7:0] exp_w;
    logic       rd_seen;
    logic [2:0] m_st;
    logic       m_f1;
    logic       m_f2;
    logic       m_v;
    logic [3:0] m_top;
    logic [3:0] m_sel;
    logic [31:0] r;
    int         err_total = 0;
    int         compares = 0;
    int         seed;
    logic [2:0] st_tab[6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [3:0] ch_tab[5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

    dss_status_bank i_dss_status_bank (.ref_clk(ref_clk), .reset_n(reset_n), .first_loop_state(first_loop_state),
        .first_loop_beyond_soft(first_loop_beyond_soft), .second_loop_beyond_soft(second_loop_beyond_soft),
        .any_input_valid(any_input_valid), .top_priority_code(top_priority_code), .selected_code(selected_code),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic ch_ok(input logic [3:0] c);
        ch_ok = 1'b0;
        foreach (ch_tab[i]) if (ch_tab[i] == c) ch_ok = 1'b1;
    endfunction

    task automatic apply(input logic [2:0] st, input logic f1, input logic f2, input logic v,
                         input logic [3:0] top, input logic [3:0] sel);
        @(posedge ref_clk);
        {first_loop_state, first_loop_beyond_soft, second_loop_beyond_soft} <= {st, f1, f2};
        {any_input_valid, top_priority_code, selected_code} <= {v, top, sel};
        // Illegal codes leave the stored field untouched
        if (st != 3'h0 && st != 3'h3) m_st = st;
        // Top field reads 0000 whenever nothing is validated
        if (!v) m_top = 4'h0;
        else if (ch_ok(top) || top == 4'h0) m_top = top;
        if (ch_ok(sel) || sel == 4'h0) m_sel = sel;
        {m_f1, m_f2, m_v} = {f1, f2, v};
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask

    task automatic chk();
        rd(7'h09, {2'h0, m_f1, m_f2, 1'h0, m_st});
        rd(7'h0a, {m_top, m_sel});
    endtask

    task automatic report_and_stop();
        $display("counts: compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Result watcher: a read taken at one edge shows its data after that edge
    always @(posedge ref_clk) rd_seen <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            exp_w = exp_q.pop_front();
            compares++;
            if (reg_rdata_ff !== exp_w) begin
                err_total++;
                $display("unexpected reg_rdata_ff expected %h seen %h", exp_w, reg_rdata_ff);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        {reset_n, reg_rd, reg_wr, reg_wdata, reg_addr} = '0;
        {first_loop_state, first_loop_beyond_soft, second_loop_beyond_soft} = '0;
        {any_input_valid, top_priority_code, selected_code} = '0;
        {m_f1, m_f2, m_v, m_top, m_sel} = '0;
        m_st = 3'h1;
        seed = 15;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(7'h09, 8'h01);
        rd(7'h0a, 8'h00);
        rd(7'h30, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            apply(st_tab[i], i[0], i[1], 1'b1, 4'h3, 4'h3);
            chk();
        end
        apply(3'h0, 1'b1, 1'b0, 1'b1, 4'h3, 4'h3);
        chk();
        apply(3'h3, 1'b0, 1'b1, 1'b1, 4'h3, 4'h3);
        chk();
        $display("test loop states done");
        for (int i = 0; i < 5; i++) begin
            apply(3'h4, 1'b0, 1'b0, 1'b1, ch_tab[i], ch_tab[4 - i]);
            chk();
        end
        apply(3'h4, 1'b0, 1'b0, 1'b1, 4'h7, 4'ha);
        chk();
        apply(3'h4, 1'b0, 1'b0, 1'b0, 4'h5, 4'h9);
        chk();
        apply(3'h4, 1'b0, 1'b0, 1'b1, 4'h6, 4'h0);
        chk();
        $display("test channel codes done");
        @(posedge ref_clk);
        {reg_addr, reg_wr, reg_wdata} <= {7'h0a, 1'b1, 8'hff};
        @(posedge ref_clk);
        {reg_addr, reg_wr, reg_wdata} <= {7'h09, 1'b1, 8'h5a};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        chk();
        $display("test write refusal done");
        for (int i = 0; i < 20; i++) begin
            r = $random(seed);
            apply(st_tab[int'(r[2:0]) % 6], r[8], r[9], r[10], ch_tab[int'(r[14:12]) % 5],
                  r[7] ? ch_tab[int'(r[6:4]) % 5] : 4'h0);
            chk();
        end
        $display("test random status done");
        repeat (3) @(posedge ref_clk);
        report_and_stop();
    end
endmodule

`default_nettype wire
